// ---- hdl/dsr_pkg.sv ----
// Constants and state types shared by the sample rate and status block.
// Assumes a single 50 MHz system clock and four external converter channels.
package dsr_pkg;

    // Clock and master timebase
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned MASTER_HZ       = 12_800_000;
    localparam int unsigned ACC_W           = 32;

    // Rate divider chain
    localparam int unsigned PRESCALE        = 256;
    localparam int unsigned PRE_W           = 8;
    localparam int unsigned DIV_W           = 5;
    localparam int unsigned DIV_MIN         = 1;
    localparam int unsigned DIV_MAX         = 31;
    localparam int unsigned MAX_RATE_SPS    = 50_000;
    localparam int unsigned BASE_RATE_SPS   = MASTER_HZ / PRESCALE;

    // Channels and data words
    localparam int unsigned NUM_CH          = 4;
    localparam int unsigned CH_W            = 2;
    localparam int unsigned ADC_BITS        = 24;
    localparam int unsigned WORD_W          = CH_W + ADC_BITS;
    localparam int unsigned FIFO_DEPTH      = 16;
    localparam logic [ADC_BITS-1:0] SAT_POS = 24'h7FFFFF;
    localparam logic [ADC_BITS-1:0] SAT_NEG = 24'h800000;

    // Filter edges as fractions of the sample rate, in thousandths
    localparam int unsigned STOP_FRAC_MILLI = 547;
    localparam int unsigned FRAC_DEN        = 1000;
    localparam int unsigned EDGE_W          = 16;
    localparam int unsigned MATH_W          = 32;
    localparam int unsigned MATH_CNT_W      = 5;

    // Calibration store layout: gains first, then offsets
    localparam int unsigned CAL_WORDS       = 8;
    localparam int unsigned CAL_ADDR_W      = 3;
    localparam int unsigned GAIN_W          = 16;
    localparam int unsigned GAIN_FRAC       = 14;
    localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h4000;

    // Status light timing
    localparam int unsigned LED_SLOT_MS     = 100;
    localparam int unsigned LED_SLOT_TICKS  = MASTER_HZ / 1000 * LED_SLOT_MS;
    localparam int unsigned LED_SLOT_IDX_W  = 3;
    localparam logic [7:0]  LED_SINGLE      = 8'h03;
    localparam logic [7:0]  LED_DOUBLE      = 8'h05;

    typedef enum logic [1:0] {CAL_REQ, CAL_WAIT, CAL_DONE} dsr_cal_st_e;
    typedef enum logic [1:0] {M_IDLE, M_FS, M_STOP} dsr_math_st_e;
    typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_PUSH} dsr_seq_st_e;

endpackage : dsr_pkg

// ---- hdl/dsr_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module dsr_fifo #(
    parameter int unsigned WIDTH = 26,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             resetn_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;
    logic             do_wr;
    logic             do_rd;

    assign full          = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty         = (wr_ptr == rd_ptr);
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign do_wr         = in_valid_in && !full;
    assign do_rd         = out_ready_in && !empty;
    assign out_data_out  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge ref_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule : dsr_fifo

// ---- hdl/dsr_led.sv ----
// Status light pattern generator paced by the master timebase tick.
// Assumes the link state inputs are synchronous to the system clock.
`timescale 1ns/10ps
module dsr_led #(
    parameter int unsigned SLOT_TICKS = dsr_pkg::LED_SLOT_TICKS
) (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic resetn_in,
    // Timebase
    input  wire logic master_tick_in,
    // Link state
    input  wire logic usb_connected_in,
    input  wire logic usb_high_speed_in,
    input  wire logic usb_configured_in,
    // Light
    output logic      led_out
);
    localparam int unsigned CW = $clog2(SLOT_TICKS);

    logic [CW-1:0]                         slot_cnt;
    logic [dsr_pkg::LED_SLOT_IDX_W-1:0]    slot_idx;
    logic [7:0]                            pattern;

    // Full-speed enumeration shows the double pattern
    assign pattern = (usb_configured_in && !usb_high_speed_in) ? dsr_pkg::LED_DOUBLE
                                                              : dsr_pkg::LED_SINGLE;

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in || !usb_connected_in) begin
            slot_cnt <= '0;
            slot_idx <= '0;
        end else if (master_tick_in) begin
            if (slot_cnt == CW'(SLOT_TICKS - 1)) begin
                slot_cnt <= '0;
                slot_idx <= slot_idx + 1'b1;
            end else begin
                slot_cnt <= slot_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            led_out <= 1'b0;
        end else if (!usb_connected_in) begin
            led_out <= 1'b0;
        end else begin
            led_out <= pattern[slot_idx];
        end
    end

endmodule : dsr_led

// ---- hdl/dsr_top.sv ----
// Sample rate generation, converter capture, calibration and status light control.
// Assumes four external converters with their own decimation filters, a calibration
// store read one word at a time, and a consumer draining the sample stream.
`timescale 1ns/10ps
module dsr_top #(
    parameter int unsigned LED_SLOT_TICKS = dsr_pkg::LED_SLOT_TICKS,
    parameter int unsigned FIFO_DEPTH     = dsr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                                        ref_clk_in,
    input  wire logic                                        resetn_in,
    // USB link state
    input  wire logic                                        usb_connected_in,
    input  wire logic                                        usb_high_speed_in,
    input  wire logic                                        usb_configured_in,
    output logic                                             led_out,
    // Acquisition control
    input  wire logic [dsr_pkg::DIV_W-1:0]                   rate_div_in,
    input  wire logic                                        acq_enable_in,
    input  wire logic                                        mode_all_in,
    input  wire logic [dsr_pkg::CH_W-1:0]                    chan_sel_in,
    output logic                                             overrun_out,
    // Converters
    output logic                                             adc_start_out,
    output logic      [dsr_pkg::DIV_W-1:0]                   adc_rate_out,
    output logic                                             filter_retune_out,
    input  wire logic [dsr_pkg::NUM_CH-1:0]                  adc_valid_in,
    input  wire logic [dsr_pkg::NUM_CH*dsr_pkg::ADC_BITS-1:0] adc_data_in,
    // Filter band report
    output logic      [dsr_pkg::EDGE_W-1:0]                  fs_hz_out,
    output logic      [dsr_pkg::EDGE_W-1:0]                  stopband_hz_out,
    output logic      [dsr_pkg::EDGE_W-1:0]                  alias_free_hz_out,
    // Calibration store
    output logic                                             cal_rd_out,
    output logic      [dsr_pkg::CAL_ADDR_W-1:0]              cal_addr_out,
    input  wire logic [dsr_pkg::ADC_BITS-1:0]                cal_data_in,
    input  wire logic                                        cal_valid_in,
    output logic                                             cal_done_out,
    // Sample stream
    output logic                                             out_valid_out,
    input  wire logic                                        out_ready_in,
    output logic      [dsr_pkg::WORD_W-1:0]                  out_data_out
);
    localparam int unsigned NCH = dsr_pkg::NUM_CH;
    localparam int unsigned AB  = dsr_pkg::ADC_BITS;
    localparam int unsigned MW  = dsr_pkg::MATH_W;

    // Gain is unsigned with GAIN_FRAC fraction bits; result saturates to the converter range
    function automatic logic [AB-1:0] apply_cal(input logic [AB-1:0]              raw,
                                                input logic [dsr_pkg::GAIN_W-1:0] gain,
                                                input logic [AB-1:0]              offs);
        logic signed [AB+dsr_pkg::GAIN_W:0] prod;
        logic signed [AB+2:0]               sum;
        prod = $signed(raw) * $signed({1'b0, gain});
        sum  = $signed(prod[AB+dsr_pkg::GAIN_FRAC+1:dsr_pkg::GAIN_FRAC]) + $signed({{3{offs[AB-1]}}, offs});
        if (sum[AB+2:AB-1] == {4{sum[AB+2]}}) begin
            apply_cal = sum[AB-1:0];
        end else if (sum[AB+2]) begin
            apply_cal = dsr_pkg::SAT_NEG;
        end else begin
            apply_cal = dsr_pkg::SAT_POS;
        end
    endfunction : apply_cal

    // Master timebase
    logic [dsr_pkg::ACC_W-1:0] tb_acc;
    logic                      master_tick;

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            tb_acc      <= '0;
            master_tick <= 1'b0;
        end else if (tb_acc + dsr_pkg::ACC_W'(dsr_pkg::MASTER_HZ) >= dsr_pkg::ACC_W'(dsr_pkg::CLK_HZ)) begin
            tb_acc      <= tb_acc + dsr_pkg::ACC_W'(dsr_pkg::MASTER_HZ) - dsr_pkg::ACC_W'(dsr_pkg::CLK_HZ);
            master_tick <= 1'b1;
        end else begin
            tb_acc      <= tb_acc + dsr_pkg::ACC_W'(dsr_pkg::MASTER_HZ);
            master_tick <= 1'b0;
        end
    end

    // Divider selection and retune
    logic [dsr_pkg::DIV_W-1:0] next_div;
    logic [dsr_pkg::DIV_W-1:0] active_div;
    logic                      div_change;

    always_comb begin
        if (rate_div_in < dsr_pkg::DIV_W'(dsr_pkg::DIV_MIN)) begin
            next_div = dsr_pkg::DIV_W'(dsr_pkg::DIV_MIN);
        end else if (rate_div_in > dsr_pkg::DIV_W'(dsr_pkg::DIV_MAX)) begin
            next_div = dsr_pkg::DIV_W'(dsr_pkg::DIV_MAX);
        end else begin
            next_div = rate_div_in;
        end
    end

    assign div_change = (next_div != active_div);

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            active_div        <= dsr_pkg::DIV_W'(dsr_pkg::DIV_MIN);
            filter_retune_out <= 1'b0;
            adc_rate_out      <= dsr_pkg::DIV_W'(dsr_pkg::DIV_MIN);
        end else begin
            active_div        <= next_div;
            filter_retune_out <= div_change;
            adc_rate_out      <= next_div;
        end
    end

    // Divide by 256, then by the selected integer
    logic [dsr_pkg::PRE_W-1:0] pre_cnt;
    logic [dsr_pkg::DIV_W-1:0] n_cnt;
    logic                      sample_tick;

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in || div_change) begin
            pre_cnt     <= '0;
            n_cnt       <= '0;
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= 1'b0;
            if (master_tick) begin
                pre_cnt <= pre_cnt + 1'b1;
                if (pre_cnt == dsr_pkg::PRE_W'(dsr_pkg::PRESCALE - 1)) begin
                    if (n_cnt == active_div - 1'b1) begin
                        n_cnt       <= '0;
                        sample_tick <= 1'b1;
                    end else begin
                        n_cnt <= n_cnt + 1'b1;
                    end
                end
            end
        end
    end

    // Calibration load from nonvolatile store
    dsr_pkg::dsr_cal_st_e     cal_st;
    logic [dsr_pkg::GAIN_W-1:0] cal_gain [NCH];
    logic [AB-1:0]              cal_offs [NCH];

    assign cal_rd_out   = (cal_st == dsr_pkg::CAL_REQ);
    assign cal_done_out = (cal_st == dsr_pkg::CAL_DONE);

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            cal_st       <= dsr_pkg::CAL_REQ;
            cal_addr_out <= '0;
            for (int i = 0; i < NCH; i++) begin
                cal_gain[i] <= dsr_pkg::GAIN_UNITY;
                cal_offs[i] <= '0;
            end
        end else begin
            case (cal_st)
                dsr_pkg::CAL_REQ: begin
                    cal_st <= dsr_pkg::CAL_WAIT;
                end
                dsr_pkg::CAL_WAIT: begin
                    if (cal_valid_in) begin
                        if (cal_addr_out < dsr_pkg::CAL_ADDR_W'(NCH)) begin
                            cal_gain[cal_addr_out[dsr_pkg::CH_W-1:0]] <= cal_data_in[dsr_pkg::GAIN_W-1:0];
                        end else begin
                            cal_offs[cal_addr_out[dsr_pkg::CH_W-1:0]] <= cal_data_in;
                        end
                        if (cal_addr_out == dsr_pkg::CAL_ADDR_W'(dsr_pkg::CAL_WORDS - 1)) begin
                            cal_st <= dsr_pkg::CAL_DONE;
                        end else begin
                            cal_addr_out <= cal_addr_out + 1'b1;
                            cal_st       <= dsr_pkg::CAL_REQ;
                        end
                    end
                end
                dsr_pkg::CAL_DONE: begin
                    cal_st <= dsr_pkg::CAL_DONE;
                end
                default: begin
                    cal_st <= dsr_pkg::CAL_REQ;
                end
            endcase
        end
    end

    // Shared start strobe for all converters
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            adc_start_out <= 1'b0;
        end else begin
            adc_start_out <= sample_tick && acq_enable_in && cal_done_out;
        end
    end

    // Per-channel capture and correction
    logic          got  [NCH];
    logic [AB-1:0] corr [NCH];

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        always_ff @(posedge ref_clk_in) begin
            if (!resetn_in) begin
                got[g]  <= 1'b0;
                corr[g] <= '0;
            end else if (adc_valid_in[g]) begin
                got[g]  <= 1'b1;
                corr[g] <= apply_cal(adc_data_in[g*AB +: AB], cal_gain[g], cal_offs[g]);
            end else if (adc_start_out) begin
                got[g]  <= 1'b0;
            end
        end
    end

    // Push sequencer into the FIFO
    dsr_pkg::dsr_seq_st_e     seq_st;
    logic                     mode_all_q;
    logic [dsr_pkg::CH_W-1:0] sel_q;
    logic [dsr_pkg::CH_W-1:0] push_ch;
    logic                     all_got;
    logic                     push_valid;
    logic                     push_ready;

    always_comb begin
        all_got = 1'b1;
        for (int i = 0; i < NCH; i++) begin
            if (!got[i]) begin
                all_got = 1'b0;
            end
        end
    end

    assign push_valid = (seq_st == dsr_pkg::SQ_PUSH);

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            seq_st     <= dsr_pkg::SQ_IDLE;
            mode_all_q <= 1'b0;
            sel_q      <= '0;
            push_ch    <= '0;
        end else begin
            case (seq_st)
                dsr_pkg::SQ_IDLE: begin
                    if (adc_start_out) begin
                        mode_all_q <= mode_all_in;
                        sel_q      <= chan_sel_in;
                        seq_st     <= dsr_pkg::SQ_WAIT;
                    end
                end
                dsr_pkg::SQ_WAIT: begin
                    if (mode_all_q ? all_got : got[sel_q]) begin
                        push_ch <= mode_all_q ? '0 : sel_q;
                        seq_st  <= dsr_pkg::SQ_PUSH;
                    end
                end
                dsr_pkg::SQ_PUSH: begin
                    if (push_ready) begin
                        if (!mode_all_q || push_ch == dsr_pkg::CH_W'(NCH - 1)) begin
                            seq_st <= dsr_pkg::SQ_IDLE;
                        end else begin
                            push_ch <= push_ch + 1'b1;
                        end
                    end
                end
                default: begin
                    seq_st <= dsr_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    // Start while previous frame still pending; set wins over clear
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            overrun_out <= 1'b0;
        end else if (adc_start_out && seq_st != dsr_pkg::SQ_IDLE) begin
            overrun_out <= 1'b1;
        end else if (!acq_enable_in) begin
            overrun_out <= 1'b0;
        end
    end

    dsr_fifo #(
        .WIDTH (dsr_pkg::WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .resetn_in     (resetn_in),
        .in_valid_in   (push_valid),
        .in_ready_out  (push_ready),
        .in_data_in    ({push_ch, corr[push_ch]}),
        .out_valid_out (out_valid_out),
        .out_ready_in  (out_ready_in),
        .out_data_out  (out_data_out)
    );

    // Filter band edges, recomputed on each rate change by a serial divider
    dsr_pkg::dsr_math_st_e            m_st;
    logic [MW-1:0]                    m_rem;
    logic [MW-1:0]                    m_quo;
    logic [MW-1:0]                    m_den;
    logic [dsr_pkg::MATH_CNT_W-1:0]   m_cnt;
    logic [MW-1:0]                    rem_sh;
    logic [MW-1:0]                    next_rem;
    logic [MW-1:0]                    next_quo;

    always_comb begin
        rem_sh = {m_rem[MW-2:0], m_quo[MW-1]};
        if (rem_sh >= m_den) begin
            next_rem = rem_sh - m_den;
            next_quo = {m_quo[MW-2:0], 1'b1};
        end else begin
            next_rem = rem_sh;
            next_quo = {m_quo[MW-2:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            m_st              <= dsr_pkg::M_FS;
            m_rem             <= '0;
            m_quo             <= MW'(dsr_pkg::BASE_RATE_SPS);
            m_den             <= MW'(dsr_pkg::DIV_MIN);
            m_cnt             <= '0;
            fs_hz_out         <= '0;
            stopband_hz_out   <= '0;
            alias_free_hz_out <= '0;
        end else if (div_change) begin
            m_st  <= dsr_pkg::M_FS;
            m_rem <= '0;
            m_quo <= MW'(dsr_pkg::BASE_RATE_SPS);
            m_den <= MW'(next_div);
            m_cnt <= '0;
        end else if (m_st != dsr_pkg::M_IDLE) begin
            m_rem <= next_rem;
            m_quo <= next_quo;
            m_cnt <= m_cnt + 1'b1;
            if (m_cnt == dsr_pkg::MATH_CNT_W'(MW - 1)) begin
                m_rem <= '0;
                m_cnt <= '0;
                if (m_st == dsr_pkg::M_FS) begin
                    fs_hz_out <= next_quo[dsr_pkg::EDGE_W-1:0];
                    m_quo     <= next_quo * MW'(dsr_pkg::STOP_FRAC_MILLI);
                    m_den     <= MW'(dsr_pkg::FRAC_DEN);
                    m_st      <= dsr_pkg::M_STOP;
                end else begin
                    stopband_hz_out   <= next_quo[dsr_pkg::EDGE_W-1:0];
                    alias_free_hz_out <= fs_hz_out - next_quo[dsr_pkg::EDGE_W-1:0];
                    m_st              <= dsr_pkg::M_IDLE;
                end
            end
        end
    end

    dsr_led #(
        .SLOT_TICKS (LED_SLOT_TICKS)
    ) u_led (
        .ref_clk_in        (ref_clk_in),
        .resetn_in         (resetn_in),
        .master_tick_in    (master_tick),
        .usb_connected_in  (usb_connected_in),
        .usb_high_speed_in (usb_high_speed_in),
        .usb_configured_in (usb_configured_in),
        .led_out           (led_out)
    );

endmodule : dsr_top

// ---- tb/dsr_top_asserts.sv ----
// Port checker for dsr_top, bound onto every instance.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/10ps
module dsr_top_chk (
    input wire logic        ref_clk_in, resetn_in, usb_connected_in, out_ready_in, led_out,
    input wire logic        adc_start_out, cal_done_out, out_valid_out,
    input wire logic [4:0]  rate_div_in, adc_rate_out,
    input wire logic [15:0] fs_hz_out, stopband_hz_out, alias_free_hz_out,
    input wire logic [25:0] out_data_out
);
    logic [7:0] settle;
    // Cycles since the band was last retuned
    always_ff @(posedge ref_clk_in) begin
        settle <= (!resetn_in || adc_rate_out != rate_div_in + 5'(rate_div_in == 5'h00)) ? 8'h00
                                                                                       : settle + 8'(settle != 8'hFF);
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    property p_rate; rate_div_in != 5'h00 |=> adc_rate_out == $past(rate_div_in); endproperty
    a_rate: assert property (p_rate) else $error("divider not taken");
    property p_clamp; rate_div_in == 5'h00 |=> adc_rate_out == 5'h01; endproperty
    a_clamp: assert property (p_clamp) else $error("divider not clamped");
    property p_pulse; adc_start_out |=> !adc_start_out; endproperty
    a_pulse: assert property (p_pulse) else $error("start too long");
    property p_gate; adc_start_out |-> cal_done_out; endproperty
    a_gate: assert property (p_gate) else $error("start before load");
    property p_dark; !usb_connected_in [*2] |-> !led_out; endproperty
    a_dark: assert property (p_dark) else $error("light lit");
    property p_stop; settle == 8'hC8 |-> stopband_hz_out == 16'(32'(fs_hz_out) * 547 / 1000); endproperty
    a_stop: assert property (p_stop) else $error("stop edge");
    property p_alias; settle == 8'hC8 |-> alias_free_hz_out == fs_hz_out - stopband_hz_out; endproperty
    a_alias: assert property (p_alias) else $error("alias band");
    property p_hold; out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out); endproperty
    a_hold: assert property (p_hold) else $error("word dropped");
endmodule : dsr_top_chk
bind dsr_top dsr_top_chk u_chk (.*);

// ---- tb/dsr_far_model.sv ----
// Converter and calibration store stand-in: slow converters, prompt store.
// Assumes the start strobe and read request of dsr_top.
`timescale 1ns/10ps
module dsr_far_model (
    input  wire logic        ref_clk_in, resetn_in, adc_start_in, cal_rd_in,
    input  wire logic [2:0]  cal_addr_in,
    output logic      [3:0]  adc_valid_out,
    output logic      [95:0] adc_data_out,
    output logic      [23:0] cal_data_out,
    output logic             cal_valid_out
);
    logic [5:0] cd;
    // Channels finish one by one, data toggles outside valid
    always_ff @(posedge ref_clk_in) begin
        cd <= !resetn_in ? 6'h00 : adc_start_in ? 6'h28 : cd - 6'(cd != 6'h00);
        adc_valid_out <= (cd != 6'h00 && cd < 6'h05) ? 4'h1 << (cd - 6'h01) : 4'h0;
        adc_data_out <= !resetn_in ? 96'h0 : (cd != 6'h00 && cd < 6'h05) ? 96'h040040030030020020010010 : ~adc_data_out;
        cal_valid_out <= cal_rd_in;
        cal_data_out <= !cal_rd_in ? ~cal_data_out : cal_addr_in[2] ? 24'(cal_addr_in) - 24'h3 : 24'h004000;
    end
endmodule : dsr_far_model

// ---- tb/tb.sv ----
// Self-checking bench for dsr_top with the far-side stand-in.
// Assumes dsr_pkg and the design files are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb;
    logic ref_clk_in = 1'b0, resetn_in = 1'b0, usb_connected_in = 1'b0, usb_high_speed_in = 1'b0, cal_valid_in;
    logic usb_configured_in = 1'b0, acq_enable_in = 1'b0, mode_all_in = 1'b1, out_ready_in = 1'b1;
    logic led_out, overrun_out, adc_start_out, filter_retune_out, cal_rd_out, cal_done_out, out_valid_out;
    logic [4:0] rate_div_in = 5'h01, adc_rate_out;
    logic [1:0] chan_sel_in = 2'h0;
    logic [3:0] adc_valid_in;
    logic [95:0] adc_data_in;
    logic [15:0] fs_hz_out, stopband_hz_out, alias_free_hz_out;
    logic [2:0] cal_addr_out;
    logic [23:0] cal_data_in;
    logic [25:0] out_data_out;
    int err_count = 0, n_compared = 0, i, k;
    always #10 ref_clk_in = ~ref_clk_in;
    dsr_top #(.LED_SLOT_TICKS(4)) u_dut (.*);
    dsr_far_model u_far (.ref_clk_in, .resetn_in, .adc_start_in(adc_start_out), .cal_rd_in(cal_rd_out),
        .cal_addr_in(cal_addr_out), .adc_valid_out(adc_valid_in), .adc_data_out(adc_data_in),
        .cal_data_out(cal_data_in), .cal_valid_out(cal_valid_in));
    function automatic logic [25:0] ew(input int g);
        ew = {2'(g), 24'(24'h010010 * (g + 1) + g + 1)};
    endfunction : ew
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    task automatic wait_hi(input bit st);
        for (i = 0; i < 3000 && (st ? adc_start_out : out_valid_out) !== 1'b1; i++) @(negedge ref_clk_in);
        if (i == 3000) begin
            err_count++;
            conclude();
        end
    endtask : wait_hi
    task automatic t_led(input logic [2:0] lnk, input int lo, input int hi);
        logic p;
        {usb_connected_in, usb_high_speed_in, usb_configured_in} = lnk;
        p = led_out;
        k = 0;
        for (i = 0; i < 1000; i++) begin
            @(negedge ref_clk_in);
            k += int'(led_out === 1'b1 && p !== 1'b1);
            p = led_out;
        end
        `CHK(k >= lo && k <= hi, 1'b1)
        $display("t_led %b done", lnk);
    endtask : t_led
    task automatic t_rate();
        acq_enable_in = 1'b1;
        wait_hi(1'b1);
        @(negedge ref_clk_in);
        wait_hi(1'b1);
        `CHK(i >= 998 && i <= 1000, 1'b1)
        rate_div_in = 5'h1F;
        @(negedge ref_clk_in);
        `CHK({filter_retune_out, adc_rate_out}, {1'b1, 5'h1F})
        repeat (300) @(negedge ref_clk_in);
        `CHK({fs_hz_out, stopband_hz_out, alias_free_hz_out}, 48'h064C037102DB)
        rate_div_in = 5'h00;
        @(negedge ref_clk_in);
        `CHK({filter_retune_out, adc_rate_out}, {1'b1, 5'h01})
        repeat (300) @(negedge ref_clk_in);
        `CHK({filter_retune_out, adc_rate_out, fs_hz_out, stopband_hz_out, alias_free_hz_out}, {6'h01, 48'hC3506AD6587A})
        acq_enable_in = 1'b0;
        repeat (200) @(negedge ref_clk_in);
        $display("t_rate done");
    endtask : t_rate
    task automatic t_fill();
        out_ready_in = 1'b0;
        acq_enable_in = 1'b1;
        repeat (6500) @(negedge ref_clk_in);
        `CHK(overrun_out, 1'b1)
        acq_enable_in = 1'b0;
        out_ready_in = 1'b1;
        k = 0;
        for (i = 0; i < 60; i++) begin
            if (out_valid_out === 1'b1) begin
                `CHK(out_data_out, ew(k % 4))
                k++;
            end
            @(negedge ref_clk_in);
        end
        `CHK({k >= 16, overrun_out}, 2'b10)
        $display("t_fill done");
    endtask : t_fill
    task automatic t_single();
        mode_all_in = 1'b0;
        for (int c = 0; c < 4; c++) begin
            chan_sel_in = 2'(c);
            acq_enable_in = 1'b1;
            wait_hi(1'b0);
            `CHK(out_data_out, ew(c))
            acq_enable_in = 1'b0;
            repeat (1100) @(negedge ref_clk_in);
        end
        $display("t_single done");
    endtask : t_single
    initial begin
        repeat (12) @(negedge ref_clk_in);
        resetn_in = 1'b1;
        repeat (200) @(negedge ref_clk_in);
        `CHK(cal_done_out, 1'b1)
        t_led(3'b000, 0, 0);
        t_led(3'b111, 7, 9);
        t_led(3'b101, 15, 17);
        t_led(3'b000, 0, 0);
        t_rate();
        t_fill();
        t_single();
        conclude();
    end
endmodule : tb
